//--- hw/trs_pkg.sv
// Summary of operation
// R1 - Receive analog reset holds clock recovery and deserializer of each channel in reset.
// R2 - Receive digital reset clears receive coding and attachment logic while asserted.
// R3 - Transmit digital reset clears transmit coding logic while asserted.
// R4 - Synthesizer power-down asserts only during a full sequence, never partial resets.
// R5 - Full sequence starts at configuration entry or management reset assert then release.
// R6 - Sequence covers all channels by default; masked channels keep their resets untouched.
// R7 - With bonded transmit clocks, software should leave the channel mask clear.
// R8 - Transmit ready asserts only after the synthesizer reports lock.
// R9 - Receive part continues only after offset calibration active goes low.
// R10 - Last step raises receive ready and drops the management-side reset.
// R11 - Transmit-only configuration skips receive waits and completes once transmit ready.
// R12 - Receive digital reset held until analog release and calibration done; transmit after lock.
`default_nettype none
package trs_pkg;
   localparam int unsigned NCH = 4;
   localparam int unsigned CLK_HZ = 20_000_000;
   // Least power-down pulse, nanoseconds
   localparam int unsigned PDN_NS = 1000;
   localparam int unsigned PDN_CYC = (PDN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // Least settle time after analog reset release, nanoseconds
   localparam int unsigned RXA_NS = 4000;
   localparam int unsigned RXA_CYC = (RXA_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CNT_W = 8;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MASK = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_CFG = 8'h0C;
   // Control fields
   localparam int unsigned CTRL_FULL_BIT = 0;
   localparam int unsigned CTRL_TX_BIT = 1;
   localparam int unsigned CTRL_RX_BIT = 2;
   // Configuration field
   localparam int unsigned CFG_TXONLY_BIT = 0;
   localparam logic CFG_TXONLY_RST = 1'b0;
   localparam logic [NCH-1:0] MASK_RST = 4'h0;
   // Status fields
   localparam int unsigned STAT_TXRDY_BIT = 0;
   localparam int unsigned STAT_RXRDY_BIT = 1;
   localparam int unsigned STAT_BUSY_BIT = 2;
   localparam int unsigned STAT_STATE_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_PDN = 3'b001,
      ST_LOCK = 3'b010,
      ST_RXA = 3'b011,
      ST_CAL = 3'b100,
      ST_DONE = 3'b101
   } trs_state_t;
endpackage
`default_nettype wire

//--- hw/trs_reg_if.sv
`default_nettype none
interface trs_reg_if;
   import trs_pkg::*;
   logic [2:0] ctrl_pulse;
   logic [NCH-1:0] mask;
   logic tx_only;
   logic [31:0] status;
   modport slave (output ctrl_pulse, output mask, output tx_only, input status);
   modport core (input ctrl_pulse, input mask, input tx_only, output status);
endinterface
`default_nettype wire

//--- hw/trs_axil_regs.sv
`default_nettype none
module trs_axil_regs
   import trs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Write address and data
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   // Write response
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // Read
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Core side
   trs_reg_if.slave regs
);
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [2:0] pulse_q;
   logic [NCH-1:0] mask_q;
   logic txonly_q;
   logic do_write;

   assign do_write = aw_have_q && w_have_q && !o_bvalid;
   assign regs.ctrl_pulse = pulse_q;
   assign regs.mask = mask_q;
   assign regs.tx_only = txonly_q;

   //------------------------------
   // Write channel
   //------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_have_q <= 1'b1;
            awaddr_q <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready)
         begin
            w_have_q <= 1'b1;
            wdata_q <= i_wdata;
            o_wready <= 1'b0;
            wstrb_q <= i_wstrb;
         end
         if (do_write)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_MASK ||
                        awaddr_q == ADDR_CFG) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (o_bvalid && i_bready)
         begin
            // Both holders are empty once the response is taken
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   //------------------------------
   // Register stores
   //------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pulse_q <= 3'h0;
         mask_q <= MASK_RST;
         txonly_q <= CFG_TXONLY_RST;
      end
      else
      begin
         pulse_q <= 3'h0;
         if (do_write && wstrb_q[0])
         begin
            if (awaddr_q == ADDR_CTRL)
               pulse_q <= wdata_q[2:0];
            if (awaddr_q == ADDR_MASK)
               mask_q <= wdata_q[NCH-1:0];
            if (awaddr_q == ADDR_CFG)
               txonly_q <= wdata_q[CFG_TXONLY_BIT];
         end
      end
   end

   //------------------------------
   // Read channel
   //------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b1;
         o_rdata <= 32'h00000000;
         o_rresp <= RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_arready <= 1'b0;
         o_rresp <= RESP_OKAY;
         case (i_araddr)
            ADDR_CTRL: o_rdata <= 32'h00000000;
            ADDR_MASK: o_rdata <= {{(32-NCH){1'b0}}, mask_q};
            ADDR_STAT: o_rdata <= regs.status;
            ADDR_CFG: o_rdata <= {31'h00000000, txonly_q};
            default:
            begin
               o_rdata <= 32'h00000000;
               o_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (o_rvalid && i_rready)
      begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- hw/trs_top.sv
`default_nettype none
module trs_top
   import trs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Configuration done and management reset
   input wire logic i_user_mode,
   input wire logic i_mgmt_reset,
   // Status from transceiver
   input wire logic i_synth_locked,
   input wire logic [trs_pkg::NCH-1:0] i_offset_cal_active,
   // Reset and power-down outputs
   output logic [trs_pkg::NCH-1:0] o_rx_analog_reset,
   output logic [trs_pkg::NCH-1:0] o_rx_digital_reset,
   output logic [trs_pkg::NCH-1:0] o_tx_digital_reset,
   output logic o_synth_powerdown,
   output logic o_tx_ready,
   output logic o_rx_ready,
   output logic o_mgmt_side_reset,
   // AXI4-Lite
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   import trs_pkg::*;

   trs_reg_if regs ();
   trs_state_t state_q;
   logic [CNT_W-1:0] cnt_q;
   logic user_q;
   logic mrst_q;
   logic full_start;
   logic cal_busy;
   logic [NCH-1:0] sel_q;

   trs_axil_regs u_regs
   (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .regs(regs)
   );

   //------------------------------
   // Start detection
   //------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         user_q <= 1'b0;
         mrst_q <= 1'b0;
      end
      else
      begin
         user_q <= i_user_mode;
         mrst_q <= i_mgmt_reset;
      end
   end

   // Entry to user mode, or falling edge of the management reset
   assign full_start = (i_user_mode && !user_q) || (mrst_q && !i_mgmt_reset); // R5
   assign cal_busy = |(i_offset_cal_active & sel_q);

   //------------------------------
   // Sequencer
   //------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         sel_q <= '0;
         o_synth_powerdown <= 1'b0;
         o_tx_ready <= 1'b0;
         o_rx_ready <= 1'b0;
         o_mgmt_side_reset <= 1'b1;
         o_rx_analog_reset <= '0;
         o_rx_digital_reset <= '0;
         o_tx_digital_reset <= '0;
      end
      else if (i_mgmt_reset)
      begin
         // Management reset holds the whole sequence off until release
         state_q <= ST_IDLE;
         o_mgmt_side_reset <= 1'b1;
         o_tx_ready <= 1'b0;
         o_rx_ready <= 1'b0;
      end
      else if (full_start)
      begin
         // Only unmasked channels take part
         sel_q <= ~regs.mask; // R6
         o_synth_powerdown <= 1'b1; // R4
         o_mgmt_side_reset <= 1'b1;
         o_tx_ready <= 1'b0;
         o_rx_ready <= 1'b0;
         o_tx_digital_reset <= o_tx_digital_reset | ~regs.mask; // R3 R6
         o_rx_digital_reset <= o_rx_digital_reset | ~regs.mask; // R2 R6
         o_rx_analog_reset <= o_rx_analog_reset | ~regs.mask; // R1 R6
         cnt_q <= CNT_W'(PDN_CYC);
         state_q <= ST_PDN;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               // Partial resets never touch the power-down
               if (regs.ctrl_pulse[CTRL_TX_BIT] || regs.ctrl_pulse[CTRL_RX_BIT])
               begin
                  sel_q <= ~regs.mask; // R6
                  o_mgmt_side_reset <= 1'b1;
                  if (regs.ctrl_pulse[CTRL_TX_BIT])
                  begin
                     o_tx_digital_reset <= o_tx_digital_reset | ~regs.mask; // R3
                     o_tx_ready <= 1'b0;
                  end
                  if (regs.ctrl_pulse[CTRL_RX_BIT] && !regs.tx_only)
                  begin
                     o_rx_analog_reset <= o_rx_analog_reset | ~regs.mask; // R1
                     o_rx_digital_reset <= o_rx_digital_reset | ~regs.mask; // R2
                     o_rx_ready <= 1'b0;
                  end
                  state_q <= ST_LOCK;
               end
               else if (regs.ctrl_pulse[CTRL_FULL_BIT])
               begin
                  // Software asks for a full restart through the same path
                  sel_q <= ~regs.mask;
                  o_synth_powerdown <= 1'b1; // R4
                  o_mgmt_side_reset <= 1'b1;
                  o_tx_ready <= 1'b0;
                  o_rx_ready <= 1'b0;
                  o_tx_digital_reset <= o_tx_digital_reset | ~regs.mask;
                  o_rx_digital_reset <= o_rx_digital_reset | ~regs.mask;
                  o_rx_analog_reset <= o_rx_analog_reset | ~regs.mask;
                  cnt_q <= CNT_W'(PDN_CYC);
                  state_q <= ST_PDN;
               end
            end
            ST_PDN:
            begin
               if (cnt_q <= CNT_W'(1))
               begin
                  o_synth_powerdown <= 1'b0;
                  state_q <= ST_LOCK;
               end
               else
               begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            ST_LOCK:
            begin
               if (i_synth_locked)
               begin
                  o_tx_digital_reset <= o_tx_digital_reset & ~sel_q; // R12
                  o_tx_ready <= 1'b1; // R8
                  if (regs.tx_only)
                  begin
                     o_rx_ready <= 1'b0;
                     o_mgmt_side_reset <= 1'b0; // R11
                     state_q <= ST_DONE;
                  end
                  else
                  begin
                     o_rx_analog_reset <= o_rx_analog_reset & ~sel_q; // R1
                     cnt_q <= CNT_W'(RXA_CYC);
                     state_q <= ST_RXA;
                  end
               end
            end
            ST_RXA:
            begin
               if (cnt_q <= CNT_W'(1))
               begin
                  state_q <= ST_CAL;
               end
               else
               begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            ST_CAL:
            begin
               if (!cal_busy) // R9
               begin
                  o_rx_digital_reset <= o_rx_digital_reset & ~sel_q; // R12
                  o_rx_ready <= 1'b1; // R10
                  o_mgmt_side_reset <= 1'b0; // R10
                  state_q <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               state_q <= ST_IDLE;
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   //------------------------------
   // Status
   //------------------------------
   assign regs.status = {25'h0000000, state_q, 1'b0,
                         (state_q != ST_IDLE), o_rx_ready, o_tx_ready};
endmodule
`default_nettype wire

//--- test/trs_xcvr_model.sv
`default_nettype none
module trs_xcvr_model
   import trs_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // From sequencer, plus lock and calibration delays from the bench
   input wire logic i_synth_powerdown,
   input wire logic [trs_pkg::NCH-1:0] i_rx_analog_reset,
   input wire logic [7:0] i_lock_dly,
   input wire logic [7:0] i_cal_dly,
   // To sequencer
   output logic o_synth_locked,
   output logic [trs_pkg::NCH-1:0] o_offset_cal_active
);
   logic [7:0] lock_cnt_q;
   // Lock is lost at once on power-down and returns after a settling delay
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lock_cnt_q <= 8'h00;
         o_synth_locked <= 1'b0;
      end
      else if (i_synth_powerdown)
      begin
         lock_cnt_q <= 8'h00;
         o_synth_locked <= 1'b0;
      end
      else
      begin
         if (lock_cnt_q < i_lock_dly)
            lock_cnt_q <= lock_cnt_q + 8'h01;
         o_synth_locked <= !(lock_cnt_q < i_lock_dly);
      end
   end
   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      logic [7:0] cnt_q;
      // Calibration runs while held in analog reset and for a while after release
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
         if (!i_rst_n)
         begin
            cnt_q <= 8'hFF;
            o_offset_cal_active[c] <= 1'b0;
         end
         else if (i_rx_analog_reset[c])
         begin
            cnt_q <= 8'h00;
            o_offset_cal_active[c] <= 1'b1;
         end
         else
         begin
            if (cnt_q < i_cal_dly)
               cnt_q <= cnt_q + 8'h01;
            o_offset_cal_active[c] <= cnt_q < i_cal_dly;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/trs_top_sva.sv
`default_nettype none
module trs_top_sva
   import trs_pkg::*;
(
   // Clock, reset and inputs
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_user_mode,
   input wire logic i_mgmt_reset,
   input wire logic i_synth_locked,
   input wire logic [trs_pkg::NCH-1:0] i_offset_cal_active,
   // Sequencer outputs
   input wire logic [trs_pkg::NCH-1:0] o_rx_analog_reset,
   input wire logic [trs_pkg::NCH-1:0] o_rx_digital_reset,
   input wire logic [trs_pkg::NCH-1:0] o_tx_digital_reset,
   input wire logic o_synth_powerdown,
   input wire logic o_tx_ready,
   input wire logic o_rx_ready,
   input wire logic o_mgmt_side_reset
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_start;
      ($rose(i_user_mode) || $fell(i_mgmt_reset)) && !i_mgmt_reset;
   endsequence
   sequence s_pdn_up;
      $rose(o_synth_powerdown);
   endsequence
   a_start_pdn:
      assert property (s_start |=> o_synth_powerdown) else $error("no powerdown after start");
   a_pdn_quiet:
      assert property (s_pdn_up |-> o_mgmt_side_reset && !o_tx_ready && !o_rx_ready)
         else $error("powerdown outside full sequence");
   a_pdn_width:
      assert property (s_pdn_up |=> o_synth_powerdown [*8]) else $error("powerdown too short");
   a_tx_lock:
      assert property ($rose(o_tx_ready) |-> $past(i_synth_locked)) else $error("tx ready early");
   a_txd_lock:
      assert property (|($past(o_tx_digital_reset) & ~o_tx_digital_reset)
         |-> $past(i_synth_locked)) else $error("tx reset released early");
   a_rxd_hold:
      assert property (|($past(o_rx_digital_reset) & ~o_rx_digital_reset)
         |-> !(|$past(o_rx_analog_reset | i_offset_cal_active)))
         else $error("rx digital reset released early");
   a_rx_last:
      assert property ($rose(o_rx_ready) |-> $fell(o_mgmt_side_reset) && o_tx_ready)
         else $error("rx ready not last step");
   a_end_tx:
      assert property ($fell(o_mgmt_side_reset) |-> o_tx_ready && !o_synth_powerdown)
         else $error("sequence ended without tx ready");
   // Length of the current power-down pulse, saturating
   logic [7:0] pd_run_q;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         pd_run_q <= 8'h00;
      else if (!o_synth_powerdown)
         pd_run_q <= 8'h00;
      else if (pd_run_q != 8'hFF)
         pd_run_q <= pd_run_q + 8'h01;
   end
   a_pdn_length:
      assert property ($fell(o_synth_powerdown) |-> pd_run_q >= PDN_CYC)
         else $error("powerdown pulse too short");
endmodule
bind trs_top trs_top_sva u_sva (.i_clk, .i_rst_n, .i_user_mode, .i_mgmt_reset, .i_synth_locked,
   .i_offset_cal_active, .o_rx_analog_reset, .o_rx_digital_reset, .o_tx_digital_reset,
   .o_synth_powerdown, .o_tx_ready, .o_rx_ready, .o_mgmt_side_reset);
`default_nettype wire

//--- test/trs_top_bench.sv
`default_nettype none
module trs_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import trs_pkg::*;
   logic i_clk, i_rst_n, i_user_mode, i_mgmt_reset, i_synth_locked;
   logic [NCH-1:0] i_offset_cal_active, o_rx_analog_reset, o_rx_digital_reset;
   logic [NCH-1:0] o_tx_digital_reset, mask;
   logic o_synth_powerdown, o_tx_ready, o_rx_ready, o_mgmt_side_reset, pd_seen;
   logic [7:0] i_awaddr, i_araddr, lock_dly, cal_dly;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0] i_wstrb;
   logic [1:0] o_bresp, o_rresp;
   logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [33:0] exp_q[$];
   logic [33:0] msk_q[$];
   logic [33:0] m;
   int bad_count;
   int cmp_count;
   int n;
   trs_top uut (.i_clk, .i_rst_n, .i_user_mode, .i_mgmt_reset, .i_synth_locked,
      .i_offset_cal_active, .o_rx_analog_reset, .o_rx_digital_reset, .o_tx_digital_reset,
      .o_synth_powerdown, .o_tx_ready, .o_rx_ready, .o_mgmt_side_reset, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
   trs_xcvr_model u_xcvr (.i_clk, .i_rst_n, .i_synth_powerdown(o_synth_powerdown),
      .i_rx_analog_reset(o_rx_analog_reset), .i_lock_dly(lock_dly), .i_cal_dly(cal_dly),
      .o_synth_locked(i_synth_locked), .o_offset_cal_active(i_offset_cal_active));
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One transfer at a time; the expected answer is queued before the request
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [33:0] e, input logic [33:0] mk);
      logic ah;
      logic wh;
      logic done;
      exp_q.push_back(e);
      msk_q.push_back(mk);
      done = 1'b0;
      @(posedge i_clk);
      {i_awaddr, i_araddr, i_wdata, i_wstrb} <= {a, a, d, s};
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= {wr, wr, wr, !wr, !wr};
      while (!done)
      begin
         @(negedge i_clk);
         ah = (i_awvalid && o_awready) || (i_arvalid && o_arready);
         wh = i_wvalid && o_wready;
         done = o_bvalid || o_rvalid;
         @(posedge i_clk);
         if (ah)
            {i_awvalid, i_arvalid} <= 2'b00;
         if (wh)
            i_wvalid <= 1'b0;
      end
      {i_bready, i_rready} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
      bus(1'b1, a, d, s, {r, 32'h0}, {2'b11, 32'h0});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
      input logic [1:0] r);
      bus(1'b0, a, 32'h0, 4'h0, {r, e}, {2'b11, mk});
   endtask
   task automatic wait_on(input int sel);
      n = 0;
      do
      begin
         @(negedge i_clk);
         n++;
      end
      while (n < 1000 && !(sel == 0 ? o_synth_powerdown === 1'b1 : sel == 1 ?
         o_tx_ready === 1'b1 : o_mgmt_side_reset === 1'b0));
      if (n >= 1000)
         bad_count++;
   endtask
   task automatic full_seq(input int how, input logic [NCH-1:0] um, input logic txo);
      if (how == 0)
         @(posedge i_clk) i_user_mode <= 1'b1;
      else if (how == 1)
      begin
         @(posedge i_clk) i_mgmt_reset <= 1'b1;
         repeat (4) @(posedge i_clk);
         i_mgmt_reset <= 1'b0;
      end
      else
         wr(ADDR_CTRL, 32'h1, 4'hF, RESP_OKAY);
      wait_on(0);
      check({o_tx_digital_reset, o_mgmt_side_reset}, {um, 1'b1});
      if (!txo)
         check({o_rx_analog_reset, o_rx_digital_reset}, {um, um});
      wait_on(1);
      check(o_tx_digital_reset, '0);
      if (!txo)
         check({o_rx_analog_reset, o_rx_digital_reset}, {{NCH{1'b0}}, um});
      wait_on(2);
      if (txo)
         check(n < RXA_CYC, 1'b1);
      else
         check({o_rx_digital_reset, o_rx_ready}, {{NCH{1'b0}}, 1'b1});
   endtask
   always @(negedge i_clk)
   begin
      if (o_synth_powerdown === 1'b1)
         pd_seen = 1'b1;
      if ((o_rvalid && i_rready) || (o_bvalid && i_bready))
      begin
         m = msk_q.pop_front();
         check((o_rvalid ? {o_rresp, o_rdata} : {o_bresp, 32'h0}) & m, exp_q.pop_front() & m);
      end
   end
   initial
   begin
      repeat (10000) @(posedge i_clk);
      bad_count++;
      wrap_up;
   end
   initial
   begin
      {i_rst_n, i_user_mode, i_mgmt_reset, i_awvalid, i_wvalid, i_bready} = '0;
      {i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
      {bad_count, cmp_count, pd_seen} = '0;
      void'($urandom(32'h05B3));
      lock_dly = 8'($urandom_range(40, 3));
      cal_dly = 8'($urandom_range(200, 90));
      mask = NCH'($urandom_range(14, 1));
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(negedge i_clk);
      check({o_synth_powerdown, o_tx_ready, o_rx_ready, o_mgmt_side_reset}, 4'h1);
      check({o_rx_analog_reset, o_rx_digital_reset, o_tx_digital_reset}, '0);
      rd(ADDR_MASK, {28'h0, MASK_RST}, 32'hF, RESP_OKAY);
      rd(ADDR_CFG, 32'h0, 32'h1, RESP_OKAY);
      rd(8'h10, 32'h0, 32'h0, RESP_SLVERR);
      full_seq(0, 4'hF, 1'b0);
      rd(ADDR_STAT, 32'h3, 32'h3, RESP_OKAY);
      wr(ADDR_MASK, {28'h0, mask}, 4'hF, RESP_OKAY);
      wr(ADDR_MASK, 32'hF, 4'h0, RESP_OKAY);
      wr(8'h14, 32'h0, 4'hF, RESP_SLVERR);
      rd(ADDR_MASK, {28'h0, mask}, 32'hF, RESP_OKAY);
      full_seq(1, ~mask, 1'b0);
      pd_seen = 1'b0;
      wr(ADDR_CTRL, 32'h2, 4'hF, RESP_OKAY);
      @(negedge i_clk);
      check({o_tx_digital_reset, o_tx_ready, o_rx_digital_reset}, {~mask, 1'b0, {NCH{1'b0}}});
      repeat (200) @(negedge i_clk);
      check({pd_seen, o_tx_ready}, 2'b01);
      wr(ADDR_CTRL, 32'h4, 4'hF, RESP_OKAY);
      @(negedge i_clk);
      check({o_rx_analog_reset, o_rx_digital_reset, o_rx_ready}, {~mask, ~mask, 1'b0});
      wait_on(2);
      check({o_rx_analog_reset, o_rx_digital_reset, o_rx_ready, o_synth_powerdown},
         {{2*NCH{1'b0}}, 2'b10});
      wr(ADDR_MASK, 32'h0, 4'hF, RESP_OKAY);
      wr(ADDR_CFG, 32'h1, 4'hF, RESP_OKAY);
      full_seq(2, 4'hF, 1'b1);
      wrap_up;
   end
endmodule
`default_nettype wire
